// [inc/audio_serial_cfg.svh]
`ifndef AUDIO_SERIAL_CFG_SVH
`define AUDIO_SERIAL_CFG_SVH

// Register indices; byte address is four times the index
`define ASP_IDX_OUT_CLK_DIV 10'h01A
`define ASP_IDX_FORMAT 10'h01B
`define ASP_IDX_OFFSET 10'h01C
`define ASP_IDX_LOOP_POL 10'h01D
`define ASP_IDX_BIT_CLK_DIV 10'h01E

`define ASP_RST_OUT_CLK_DIV 8'h01
`define ASP_RST_FORMAT 8'h00
`define ASP_RST_OFFSET 8'h00
`define ASP_RST_LOOP_POL 8'h00
`define ASP_RST_BIT_CLK_DIV 8'h01

// Field positions
`define ASP_DIV_PWR_BIT 7
`define ASP_FMT_MSB 7
`define ASP_FMT_LSB 6
`define ASP_WL_MSB 5
`define ASP_WL_LSB 4
`define ASP_BCLK_DIR_BIT 3
`define ASP_WCLK_DIR_BIT 2
`define ASP_FMT_RSVD_BIT 1
`define ASP_HIZ_BIT 0
`define ASP_SER_LOOP_BIT 5
`define ASP_CONV_LOOP_BIT 4
`define ASP_POL_BIT 3
`define ASP_BUF_PWR_BIT 2
`define ASP_BDIV_MSB 1
`define ASP_BDIV_LSB 0

`endif

// [inc/audio_serial_pkg.sv]
package audio_serial_pkg;

  typedef enum logic [1:0] {
    FMT_I2S,
    FMT_DSP,
    FMT_RIGHT_JUSTIFIED,
    FMT_LEFT_JUSTIFIED
  } frame_format_e;

  typedef enum logic [1:0] {
    BDIV_PLAYBACK_CLOCK,
    BDIV_PLAYBACK_MODULATOR_CLOCK,
    BDIV_RECORD_CLOCK,
    BDIV_RECORD_MODULATOR_CLOCK
  } bit_divider_input_e;

  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
  } stereo_sample_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

endpackage : audio_serial_pkg

// [hdl/clock_divider.sv]
`timescale 1ns/1ps
// Divides a slow level clock by a 7-bit code, zero meaning 128
module clock_divider #(
  parameter int DIV_W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic power_up,
  input wire logic [DIV_W-1:0] div_code,
  // Clock in and out
  input wire logic src,
  output logic div_out
);

  // Width refused at elaboration
  if (DIV_W < 2 || DIV_W > 16)
  begin : g_bad_width
    $error("clock_divider: DIV_W out of range");
  end

  logic src_q;
  logic [DIV_W:0] count;
  logic [DIV_W:0] divisor;
  logic [DIV_W:0] half;
  logic src_rise;
  logic wrap;
  logic [DIV_W:0] next_count;

  assign divisor = (div_code == '0) ? (DIV_W+1)'(1 << DIV_W)
                                    : {1'b0, div_code};
  assign half = (divisor + (DIV_W+1)'(1)) >> 1;
  assign src_rise = src & ~src_q;
  assign wrap = (count >= divisor - (DIV_W+1)'(1));
  assign next_count = !src_rise ? count
                    : wrap ? '0 : count + (DIV_W+1)'(1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      src_q <= 1'b0;
      count <= '0;
      div_out <= 1'b0;
    end
    else if (!power_up)
    begin
      src_q <= 1'b0;
      count <= '0;
      div_out <= 1'b0;
    end
    else
    begin
      src_q <= src;
      count <= next_count;
      div_out <= (divisor == (DIV_W+1)'(1)) ? src : (next_count < half);
    end
  end

endmodule : clock_divider

// [hdl/word_clock_gen.sv]
`timescale 1ns/1ps
// Generates the frame clock from bit clock launch edges
module word_clock_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic bit_tick,
  input wire logic [5:0] word_bits,
  input wire audio_serial_pkg::frame_format_e fmt,
  // Frame clock
  output logic wclk
);

  logic [6:0] bit_cnt;
  logic [6:0] frame_bits;
  logic [6:0] next_cnt;
  logic first_half;

  assign frame_bits = {word_bits, 1'b0};
  assign next_cnt = (bit_cnt >= frame_bits - 7'h01) ? 7'h00
                                                   : bit_cnt + 7'h01;
  assign first_half = (next_cnt < {1'b0, word_bits});

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt <= 7'h7F;
      wclk <= 1'b0;
    end
    else if (!enable)
    begin
      bit_cnt <= 7'h7F;
      wclk <= 1'b0;
    end
    else if (bit_tick)
    begin
      bit_cnt <= next_cnt;
      unique case (fmt)
        audio_serial_pkg::FMT_I2S: wclk <= ~first_half;
        audio_serial_pkg::FMT_DSP: wclk <= (next_cnt == 7'h00);
        audio_serial_pkg::FMT_RIGHT_JUSTIFIED,
        audio_serial_pkg::FMT_LEFT_JUSTIFIED: wclk <= first_half;
      endcase
    end
  end

endmodule : word_clock_gen

// [hdl/audio_serial_port_config.sv]
`timescale 1ns/1ps
`include "audio_serial_cfg.svh"
module audio_serial_port_config (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave
  input wire audio_serial_pkg::apb_req_s APB_REQ,
  output audio_serial_pkg::apb_rsp_s APB_RSP,
  // Clock sources, slow levels synchronous to REF_CLK
  input wire logic OUTPUT_CLOCK_SOURCE,
  input wire logic PLAYBACK_CLOCK,
  input wire logic PLAYBACK_MODULATOR_CLOCK,
  input wire logic RECORD_CLOCK,
  input wire logic RECORD_MODULATOR_CLOCK,
  input wire logic CODEC_POWERED,
  output logic OUTPUT_CLOCK,
  // Serial pins
  input wire logic BCLK_IN,
  output logic BCLK_OUT,
  output logic BCLK_OE,
  input wire logic WCLK_IN,
  output logic WCLK_OUT,
  output logic WCLK_OE,
  input wire logic DIN,
  output logic DOUT,
  output logic DOUT_OE,
  // Converter samples
  input wire audio_serial_pkg::stereo_sample_s RECORD_SAMPLE,
  output audio_serial_pkg::stereo_sample_s PLAYBACK_SAMPLE
);

  logic [7:0] out_clk_div;
  logic [7:0] format_ctrl;
  logic [7:0] data_offset;
  logic [7:0] loop_pol;
  logic [7:0] bit_clk_div;

  // APB decode
  logic [9:0] word_idx;
  logic hit_out_clk;
  logic hit_format;
  logic hit_offset;
  logic hit_loop;
  logic hit_bit_clk;
  logic mapped;
  logic setup_phase;
  logic write_now;
  logic [7:0] read_mux;

  assign word_idx = APB_REQ.paddr[11:2];
  assign hit_out_clk = (word_idx == `ASP_IDX_OUT_CLK_DIV);
  assign hit_format = (word_idx == `ASP_IDX_FORMAT);
  assign hit_offset = (word_idx == `ASP_IDX_OFFSET);
  assign hit_loop = (word_idx == `ASP_IDX_LOOP_POL);
  assign hit_bit_clk = (word_idx == `ASP_IDX_BIT_CLK_DIV);
  assign mapped = hit_out_clk | hit_format | hit_offset | hit_loop
                | hit_bit_clk;
  assign setup_phase = APB_REQ.psel & ~APB_REQ.penable;
  assign write_now = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready
                   & APB_REQ.pwrite & mapped;
  assign read_mux = hit_out_clk ? out_clk_div
                  : hit_format ? format_ctrl
                  : hit_offset ? data_offset
                  : hit_loop ? loop_pol
                  : hit_bit_clk ? bit_clk_div : 8'h00;

  // Zero-wait answer: pready in the cycle after setup
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      APB_RSP <= '0;
    else
    begin
      APB_RSP.pready <= setup_phase;
      APB_RSP.pslverr <= setup_phase & ~mapped;
      APB_RSP.prdata <= (setup_phase & ~APB_REQ.pwrite)
                        ? {24'h000000, read_mux} : 32'h00000000;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      out_clk_div <= `ASP_RST_OUT_CLK_DIV;
      format_ctrl <= `ASP_RST_FORMAT;
      data_offset <= `ASP_RST_OFFSET;
      loop_pol <= `ASP_RST_LOOP_POL;
      bit_clk_div <= `ASP_RST_BIT_CLK_DIV;
    end
    else if (write_now)
    begin
      if (hit_out_clk)
        out_clk_div <= APB_REQ.pwdata[7:0];
      if (hit_format)
      begin
        format_ctrl <= APB_REQ.pwdata[7:0];
        format_ctrl[`ASP_FMT_RSVD_BIT] <= 1'b0;
      end
      if (hit_offset)
        data_offset <= APB_REQ.pwdata[7:0];
      if (hit_loop)
        loop_pol <= APB_REQ.pwdata[7:0];
      if (hit_bit_clk)
        bit_clk_div <= APB_REQ.pwdata[7:0];
    end
  end

  // Field views
  audio_serial_pkg::frame_format_e fmt;
  audio_serial_pkg::bit_divider_input_e bdiv_sel;
  logic [5:0] word_bits;
  logic bclk_dir;
  logic wclk_dir;
  logic hiz_after_word;
  logic serial_loop;
  logic conv_loop;
  logic bclk_invert;
  logic buf_keep;

  assign fmt = audio_serial_pkg::frame_format_e'(
               format_ctrl[`ASP_FMT_MSB:`ASP_FMT_LSB]);
  assign word_bits = (format_ctrl[`ASP_WL_MSB:`ASP_WL_LSB] == 2'b00) ? 6'd16
                   : (format_ctrl[`ASP_WL_MSB:`ASP_WL_LSB] == 2'b01) ? 6'd20
                   : (format_ctrl[`ASP_WL_MSB:`ASP_WL_LSB] == 2'b10) ? 6'd24
                   : 6'd32;
  assign bclk_dir = format_ctrl[`ASP_BCLK_DIR_BIT];
  assign wclk_dir = format_ctrl[`ASP_WCLK_DIR_BIT];
  assign hiz_after_word = format_ctrl[`ASP_HIZ_BIT];
  assign serial_loop = loop_pol[`ASP_SER_LOOP_BIT];
  assign conv_loop = loop_pol[`ASP_CONV_LOOP_BIT];
  assign bclk_invert = loop_pol[`ASP_POL_BIT];
  assign buf_keep = loop_pol[`ASP_BUF_PWR_BIT];
  assign bdiv_sel = audio_serial_pkg::bit_divider_input_e'(
                    loop_pol[`ASP_BDIV_MSB:`ASP_BDIV_LSB]);

  // Dividers
  logic bdiv_src;
  logic n_div_out;

  assign bdiv_src = (bdiv_sel == audio_serial_pkg::BDIV_PLAYBACK_CLOCK)
                    ? PLAYBACK_CLOCK
                  : (bdiv_sel ==
                     audio_serial_pkg::BDIV_PLAYBACK_MODULATOR_CLOCK)
                    ? PLAYBACK_MODULATOR_CLOCK
                  : (bdiv_sel == audio_serial_pkg::BDIV_RECORD_CLOCK)
                    ? RECORD_CLOCK : RECORD_MODULATOR_CLOCK;

  clock_divider #(.DIV_W(7)) m_divider (
    .clk(REF_CLK),
    .rst(RST),
    .power_up(out_clk_div[`ASP_DIV_PWR_BIT]),
    .div_code(out_clk_div[6:0]),
    .src(OUTPUT_CLOCK_SOURCE),
    .div_out(OUTPUT_CLOCK)
  );

  clock_divider #(.DIV_W(7)) n_divider (
    .clk(REF_CLK),
    .rst(RST),
    .power_up(bit_clk_div[`ASP_DIV_PWR_BIT]),
    .div_code(bit_clk_div[6:0]),
    .src(bdiv_src),
    .div_out(n_div_out)
  );

  // Clock buffers and direction
  logic buf_on;
  logic bclk_int;
  logic bclk_q;
  logic bit_rise;
  logic bit_fall;
  logic fall_d;
  logic gen_wclk;
  logic wclk_int;

  assign buf_on = CODEC_POWERED
                | (buf_keep & (bclk_dir | wclk_dir));
  assign bclk_int = (bclk_dir ? n_div_out : (BCLK_IN & buf_on))
                  ^ bclk_invert;
  assign bit_rise = bclk_int & ~bclk_q;
  assign bit_fall = ~bclk_int & bclk_q;
  assign wclk_int = wclk_dir ? gen_wclk : (WCLK_IN & buf_on);

  word_clock_gen frame_gen (
    .clk(REF_CLK),
    .rst(RST),
    .enable(wclk_dir & buf_on),
    .bit_tick(bit_fall),
    .word_bits(word_bits),
    .fmt(fmt),
    .wclk(gen_wclk)
  );

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      bclk_q <= 1'b0;
      fall_d <= 1'b0;
      BCLK_OUT <= 1'b0;
      BCLK_OE <= 1'b0;
      WCLK_OUT <= 1'b0;
      WCLK_OE <= 1'b0;
    end
    else
    begin
      bclk_q <= bclk_int;
      fall_d <= bit_fall;
      BCLK_OUT <= n_div_out ^ bclk_invert;
      BCLK_OE <= bclk_dir & buf_on;
      WCLK_OUT <= gen_wclk;
      WCLK_OE <= wclk_dir & buf_on;
    end
  end

  // Frame position, advanced one cycle after each launch edge
  logic wclk_prev;
  logic wclk_change;
  logic chan_start;
  logic [9:0] bit_cnt;
  logic [9:0] half_len;
  logic [9:0] next_cnt;
  logic [9:0] delay;
  logic [9:0] rj_pad;
  logic [9:0] span;
  logic [9:0] word_pos;
  logic in_word;
  logic right_chan;
  logic left_start;
  logic [31:0] tx_left;
  logic [31:0] tx_right;
  logic [31:0] tx_word;
  logic [31:0] rx_shift;

  assign wclk_change = (wclk_int != wclk_prev);
  assign chan_start = wclk_change
                    & ((fmt != audio_serial_pkg::FMT_DSP) | wclk_int);
  assign next_cnt = chan_start ? 10'h000
                  : (bit_cnt == 10'h3FF) ? bit_cnt : bit_cnt + 10'h001;
  assign rj_pad = (half_len > {4'h0, word_bits})
                  ? half_len - {4'h0, word_bits} : 10'h000;
  assign delay = {2'b00, data_offset}
               + ((fmt == audio_serial_pkg::FMT_I2S) ? 10'h001 : 10'h000)
               + ((fmt == audio_serial_pkg::FMT_RIGHT_JUSTIFIED)
                  ? rj_pad : 10'h000);
  assign span = (fmt == audio_serial_pkg::FMT_DSP)
                ? {3'b000, word_bits, 1'b0} : {4'h0, word_bits};
  assign in_word = (bit_cnt >= delay) && (bit_cnt < delay + span);
  assign word_pos = (bit_cnt >= delay + {4'h0, word_bits})
                    ? bit_cnt - delay - {4'h0, word_bits}
                    : bit_cnt - delay;
  assign right_chan = (fmt == audio_serial_pkg::FMT_DSP)
                      ? (bit_cnt >= delay + {4'h0, word_bits})
                    : (fmt == audio_serial_pkg::FMT_I2S)
                      ? wclk_prev : ~wclk_prev;
  assign left_start = chan_start & ~right_chan_next(wclk_int);
  assign tx_word = right_chan ? tx_right : tx_left;

  function automatic logic right_chan_next(input logic level);
    right_chan_next = (fmt == audio_serial_pkg::FMT_I2S) ? level
                    : (fmt == audio_serial_pkg::FMT_DSP) ? 1'b0 : ~level;
  endfunction : right_chan_next

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      wclk_prev <= 1'b0;
      bit_cnt <= 10'h3FF;
      half_len <= 10'h000;
      tx_left <= 32'h00000000;
      tx_right <= 32'h00000000;
    end
    else if (fall_d)
    begin
      wclk_prev <= wclk_int;
      bit_cnt <= next_cnt;
      if (chan_start)
        half_len <= bit_cnt + 10'h001;
      if (left_start)
      begin
        tx_left <= RECORD_SAMPLE.left;
        tx_right <= RECORD_SAMPLE.right;
      end
    end
  end

  // Data out, launched on the delayed launch edge
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      DOUT <= 1'b0;
      DOUT_OE <= 1'b0;
    end
    else if (serial_loop)
    begin
      DOUT <= DIN;
      DOUT_OE <= 1'b1;
    end
    else if (fall_d)
    begin
      DOUT <= in_word ? tx_word[5'(word_bits - 6'd1 - word_pos[5:0])]
                      : 1'b0;
      DOUT_OE <= ~hiz_after_word | in_word;
    end
  end

  // Data in, captured on the capture edge
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      rx_shift <= 32'h00000000;
      PLAYBACK_SAMPLE <= '0;
    end
    else if (conv_loop)
    begin
      if (fall_d && left_start)
        PLAYBACK_SAMPLE <= RECORD_SAMPLE;
    end
    else if (bit_rise && in_word)
    begin
      // Cleared at word start so the sample stays right aligned
      rx_shift <= (word_pos == 10'h000) ? {31'h00000000, DIN}
                                        : {rx_shift[30:0], DIN};
      if (word_pos == {4'h0, word_bits} - 10'h001)
      begin
        if (right_chan)
          PLAYBACK_SAMPLE.right <= {rx_shift[30:0], DIN};
        else
          PLAYBACK_SAMPLE.left <= {rx_shift[30:0], DIN};
      end
    end
  end

endmodule : audio_serial_port_config

// [verification/audio_serial_port_config_monitor.sv]
`timescale 1ns/1ps
`include "audio_serial_cfg.svh"
module audio_serial_port_config_monitor (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register bus
  input wire audio_serial_pkg::apb_req_s APB_REQ,
  input wire audio_serial_pkg::apb_rsp_s APB_RSP,
  // Clocks and serial pins
  input wire logic CODEC_POWERED,
  input wire logic OUTPUT_CLOCK,
  input wire logic BCLK_OUT,
  input wire logic BCLK_OE,
  input wire logic WCLK_OE,
  input wire logic DIN,
  input wire logic DOUT,
  input wire logic DOUT_OE,
  // Samples
  input wire audio_serial_pkg::stereo_sample_s RECORD_SAMPLE,
  input wire audio_serial_pkg::stereo_sample_s PLAYBACK_SAMPLE
);
  logic [7:0] ocd, fmt, lp, bcd;
  wire [9:0] idx = APB_REQ.paddr[11:2];
  wire wr = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready
    && APB_REQ.pwrite;
  wire [7:0] wd = APB_REQ.pwdata[7:0];
  // Mirror of the control registers other than the data offset
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ocd <= 8'h01;
      fmt <= 8'h00;
      lp <= 8'h00;
      bcd <= 8'h01;
    end
    else if (wr)
    begin
      if (idx == `ASP_IDX_OUT_CLK_DIV) ocd <= wd;
      if (idx == `ASP_IDX_FORMAT) fmt <= wd;
      if (idx == `ASP_IDX_LOOP_POL) lp <= wd;
      if (idx == `ASP_IDX_BIT_CLK_DIV) bcd <= wd;
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_rsvd_zero;
    APB_RSP.pready && !APB_REQ.pwrite && idx == `ASP_IDX_FORMAT
      |-> APB_RSP.prdata[1] == 1'b0 && APB_RSP.prdata[31:8] == 24'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved format bit read nonzero");
  property p_bclk_in;
    (!fmt[3])[*4] |-> !BCLK_OE;
  endproperty
  a_bclk_in: assert property (p_bclk_in)
    else $error("bit clock driven while input");
  property p_wclk_in;
    (!fmt[2])[*4] |-> !WCLK_OE;
  endproperty
  a_wclk_in: assert property (p_wclk_in)
    else $error("word clock driven while input");
  property p_ser_loop;
    lp[5][*4] |-> DOUT == $past(DIN) && DOUT_OE;
  endproperty
  a_ser_loop: assert property (p_ser_loop)
    else $error("serial loopback data wrong");
  property p_conv_loop;
    lp[4][*8] ##0 $changed(PLAYBACK_SAMPLE)
      |-> PLAYBACK_SAMPLE == $past(RECORD_SAMPLE);
  endproperty
  a_conv_loop: assert property (p_conv_loop)
    else $error("converter loopback sample wrong");
  property p_m_off;
    (!ocd[7])[*4] |=> $stable(OUTPUT_CLOCK);
  endproperty
  a_m_off: assert property (p_m_off)
    else $error("output clock moves while divider off");
  property p_n_off;
    (fmt[3] && !bcd[7] && $stable(lp[3]))[*4] |=> $stable(BCLK_OUT);
  endproperty
  a_n_off: assert property (p_n_off)
    else $error("bit clock moves while divider off");
  property p_buf_off;
    (!lp[2] && !CODEC_POWERED)[*4] |-> !BCLK_OE && !WCLK_OE;
  endproperty
  a_buf_off: assert property (p_buf_off)
    else $error("clock buffers on while codec off");
  c_bclk_gen: cover property (BCLK_OE && $rose(BCLK_OUT));
  c_loop: cover property (lp[5] && DOUT_OE);
  c_err: cover property (APB_RSP.pslverr);
endmodule : audio_serial_port_config_monitor

// [verification/host_serial_model.sv]
`timescale 1ns/1ps
// Host end: bit clock, frame clock and data in, 32-bit slots
module host_serial_model (
  // Clock
  input wire logic clk,
  // Control
  input wire logic run,
  input wire logic [7:0] offset,
  input wire logic [15:0] left,
  input wire logic [15:0] right,
  // Serial lines
  output logic bclk,
  output logic wclk,
  output logic din
);
  logic [1:0] ph = 2'h0;
  logic [5:0] bit_no = 6'h0;
  wire [5:0] nb = bit_no + 6'h1;
  wire [6:0] lpos = 7'(nb) - 7'(offset) - 7'h1;
  wire [6:0] rpos = lpos - 7'h20;
  wire nd = lpos < 7'h10 ? left[4'hF - lpos[3:0]] :
    rpos < 7'h10 ? right[4'hF - rpos[3:0]] : 1'b0;
  initial
  begin
    bclk = 1'b0;
    wclk = 1'b0;
    din = 1'b0;
  end
  always @(posedge clk)
  begin
    if (!run)
    begin
      bclk <= 1'b0;
      din <= ~din;
    end
    else
    begin
      ph <= ph + 2'h1;
      if (ph == 2'h3)
      begin
        bclk <= ~bclk;
        if (bclk)
        begin
          bit_no <= nb;
          wclk <= nb >= 6'h20;
          din <= nd;
        end
      end
    end
  end
endmodule : host_serial_model

// [verification/audio_serial_port_config_tb.sv]
`timescale 1ns/1ps
`include "audio_serial_cfg.svh"
module audio_serial_port_config_tb;
  logic ref_clk, rst, cpw, run, err, prev;
  logic oclk, bo, boe, wo, woe, dout, doe, hb, hw, hd;
  logic [4:0] sk = 5'h0;
  logic [7:0] off;
  logic [15:0] hl, hr;
  logic [31:0] rd, v;
  audio_serial_pkg::apb_req_s req;
  audio_serial_pkg::apb_rsp_s rsp;
  audio_serial_pkg::stereo_sample_s rec, play;
  int fails, num_checks, cyc, p, sc [5];
  int nn [4] = '{4, 3, 0, 1};
  logic [9:0] ix [5] = '{`ASP_IDX_OUT_CLK_DIV, `ASP_IDX_FORMAT,
    `ASP_IDX_OFFSET, `ASP_IDX_LOOP_POL, `ASP_IDX_BIT_CLK_DIV};
  logic [7:0] rv [5] = '{`ASP_RST_OUT_CLK_DIV, `ASP_RST_FORMAT,
    `ASP_RST_OFFSET, `ASP_RST_LOOP_POL, `ASP_RST_BIT_CLK_DIV};
  wire bw = boe ? bo : hb;
  wire ww = woe ? wo : hw;
  audio_serial_port_config audio_serial_port_config_i (
    .REF_CLK(ref_clk), .RST(rst), .APB_REQ(req), .APB_RSP(rsp),
    .OUTPUT_CLOCK_SOURCE(sk[4]), .PLAYBACK_CLOCK(sk[0]),
    .PLAYBACK_MODULATOR_CLOCK(sk[1]), .RECORD_CLOCK(sk[2]),
    .RECORD_MODULATOR_CLOCK(sk[3]), .CODEC_POWERED(cpw),
    .OUTPUT_CLOCK(oclk), .BCLK_IN(bw), .BCLK_OUT(bo), .BCLK_OE(boe),
    .WCLK_IN(ww), .WCLK_OUT(wo), .WCLK_OE(woe), .DIN(hd), .DOUT(dout),
    .DOUT_OE(doe), .RECORD_SAMPLE(rec), .PLAYBACK_SAMPLE(play));
  host_serial_model host_serial_model_i (.clk(ref_clk), .run(run),
    .offset(off), .left(hl), .right(hr), .bclk(hb), .wclk(hw), .din(hd));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Source clocks, half periods of 2 to 6 cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      complete_run();
    end
    for (int i = 0; i < 5; i++)
    begin
      sc[i] <= sc[i] == i + 1 ? 0 : sc[i] + 1;
      if (sc[i] == i + 1) sk[i] <= ~sk[i];
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic xfer(input logic w, input logic [9:0] a,
    input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, {a, 2'h0}, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge ref_clk);
  endtask : xfer
  // Cycles between two rising edges of the chosen clock
  task automatic period(input bit m, output int n);
    logic last;
    int r, t0;
    last = m ? oclk : bo;
    r = 0;
    t0 = 0;
    n = 0;
    while (r < 3 && n < 5000)
    begin
      @(posedge ref_clk);
      n++;
      if ((m ? oclk : bo) && !last) r++;
      if ((m ? oclk : bo) && !last && r == 2) t0 = n;
      last = m ? oclk : bo;
    end
    n = n - t0;
  endtask : period
  task automatic gaps(output int c);
    c = 0;
    repeat (600)
    begin
      @(posedge ref_clk);
      c += 32'(!doe);
    end
  endtask : gaps
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial
  begin
    req = '0;
    rst = 1'b1;
    cpw = 1'b1;
    run = 1'b0;
    off = 8'h00;
    hl = 16'hA5C3;
    hr = 16'h3C5A;
    rec = '{32'h00001234, 32'h00008765};
    tick(5);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++)
    begin
      xfer(0, ix[i], 32'h0);
      check("reset value", rd, 32'(rv[i]));
      xfer(1, ix[i], i == 1 ? 32'hFFFFFFFD : 32'hFFFFFFFF);
      xfer(0, ix[i], 32'h0);
      check("all ones", rd, i == 1 ? 32'hFD : 32'hFF);
      xfer(1, ix[i], 32'(rv[i]));
    end
    xfer(0, 10'h01F, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    $display("register test done");
    xfer(1, `ASP_IDX_FORMAT, 32'h08);
    for (int m = 0; m < 4; m++)
    begin
      xfer(1, `ASP_IDX_LOOP_POL, 32'(m));
      xfer(1, `ASP_IDX_BIT_CLK_DIV, 32'h80 | 32'(nn[m]));
      period(0, p);
      check("bit clock period", p,
        2 * (m + 2) * (nn[m] == 0 ? 128 : nn[m]));
    end
    check("bit clock driven", 32'(boe), 32'h1);
    xfer(1, `ASP_IDX_BIT_CLK_DIV, 32'h04);
    tick(8);
    v = 32'(bo);
    xfer(1, `ASP_IDX_LOOP_POL, 32'h08);
    tick(8);
    check("inverted bit clock", 32'(bo), v ^ 32'h1);
    xfer(1, `ASP_IDX_OUT_CLK_DIV, 32'h83);
    period(1, p);
    check("output clock /3", p, 36);
    xfer(1, `ASP_IDX_OUT_CLK_DIV, 32'h80);
    period(1, p);
    check("output clock /128", p, 1536);
    xfer(1, `ASP_IDX_FORMAT, 32'h0C);
    tick(8);
    check("word clock driven", 32'(woe), 32'h1);
    cpw <= 1'b0;
    xfer(1, `ASP_IDX_LOOP_POL, 32'h00);
    tick(8);
    check("buffers off", 32'({boe, woe}), 32'h0);
    xfer(1, `ASP_IDX_LOOP_POL, 32'h04);
    tick(8);
    check("buffers kept", 32'({boe, woe}), 32'h3);
    cpw <= 1'b1;
    $display("clock test done");
    xfer(1, `ASP_IDX_FORMAT, 32'h00);
    xfer(1, `ASP_IDX_LOOP_POL, 32'h00);
    run <= 1'b1;
    tick(1600);
    check("left word", play.left, 32'(hl));
    check("right word", play.right, 32'(hr));
    gaps(p);
    check("data out held", 32'(p), 32'h0);
    xfer(1, `ASP_IDX_FORMAT, 32'h01);
    gaps(p);
    check("data out released", 32'(p > 0), 32'h1);
    xfer(1, `ASP_IDX_OFFSET, 32'h05);
    off <= 8'h05;
    hl <= 16'h5AF0;
    tick(1600);
    check("offset word", play.left, 32'h00005AF0);
    xfer(1, `ASP_IDX_LOOP_POL, 32'h20);
    tick(4);
    prev = hd;
    repeat (20)
    begin
      @(posedge ref_clk);
      check("serial loopback", 32'({doe, dout}), 32'({1'b1, prev}));
      prev = hd;
    end
    xfer(1, `ASP_IDX_LOOP_POL, 32'h10);
    tick(1600);
    check("converter loopback", play.left, rec.left);
    check("converter loopback", play.right, rec.right);
    run <= 1'b0;
    $display("serial test done");
    complete_run();
  end
endmodule : audio_serial_port_config_tb
bind audio_serial_port_config audio_serial_port_config_monitor
  audio_serial_port_config_monitor_i (.REF_CLK, .RST, .APB_REQ, .APB_RSP,
  .CODEC_POWERED, .OUTPUT_CLOCK, .BCLK_OUT, .BCLK_OE, .WCLK_OE, .DIN,
  .DOUT, .DOUT_OE, .RECORD_SAMPLE, .PLAYBACK_SAMPLE);
